// file: common/lzcsm_pkg.sv
// package: register map, field positions, reset values and timing counts
package lzcsm_pkg;
  // register indices (byte address is four times the low six bits of the index)
  localparam logic [7:0] IDX_LINE_PERIOD_OR_FREQUENCY  = 8'h0a;
  localparam logic [7:0] IDX_MODE_ONE  = 8'h0b;
  localparam logic [7:0] IDX_MODE_TWO  = 8'h0c;
  localparam logic [7:0] IDX_TOUT      = 8'h11;
  localparam logic [7:0] IDX_DIP_CYC   = 8'h13;
  localparam logic [7:0] IDX_DIP_LVL   = 8'h14;
  localparam logic [7:0] IDX_MIRQ_EN3  = 8'hdb;
  localparam logic [7:0] IDX_MIRQ_ST3  = 8'hde;
  localparam logic [7:0] IDX_SUP_EN    = 8'hec;
  localparam logic [7:0] IDX_SUP_FLAGS = 8'hf8;
  // field positions
  localparam int INTEG_EN_BIT  = 5;
  localparam int LPF_BYP_BIT   = 6;
  localparam int FREQ_SEL_BIT  = 1;
  localparam int ZX_BIT        = 0;
  localparam int CROSSING_TIMEOUT_FLAG_BIT      = 1;
  localparam int DIP_BIT       = 5;
  // reset values
  localparam logic [11:0] TOUT_RST   = 12'h0fff;
  localparam logic [7:0]  DIPCYC_RST = 8'h04;
  localparam logic [15:0] DIPLVL_RST = 16'h0000;
  // timing: clock and derived dividers
  localparam int CLK_HZ       = 25_000_000;
  localparam int MCLK_HZ      = 4_096_000;
  localparam int TOUT_DIV     = 160;
  localparam int PER_DIV      = 10;
  localparam int FREQ_LSB_DEN = 16;
  // frequency constant: f*16 = 16*MCLK/10 / period
  localparam int FREQ_NUM     = FREQ_LSB_DEN * MCLK_HZ / PER_DIV;
  // one-pole filter shift (corner near 63.7 Hz at sample rate MCLK/160)
  localparam int LPF_SHIFT    = 6;
endpackage : lzcsm_pkg

// file: hw/lzcsm_divider.sv
// divider: one-cycle enable every DIV cycles of the core clock
`timescale 1ns/1ps
module lzcsm_divider #(
  parameter int DIV = 10
) (
  input  wire logic core_clk_i,
  input  wire logic sys_rst_i,
  output logic      tick_o
);
  localparam int W = $clog2(DIV + 1);
  logic [W-1:0] cnt;
  wire          wrap = (cnt == W'(DIV - 1));
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt    <= '0;
      tick_o <= 1'b0;
    end else begin
      cnt    <= wrap ? '0 : cnt + 1'b1;
      tick_o <= wrap;
    end
  end
endmodule : lzcsm_divider

// file: hw/lzcsm_monitor.sv
// line zero-cross, timeout, period and dip monitor with wishbone slave
//
// Overview of operation
// - integrator off at reset; enable bit 5 of mode one turns it on
// - integrator gives -20 dB/dec and about -90 degrees phase
// - zero cross taken from voltage filter output; filter bypassable
// - single pole filter, corner 63.7 Hz, about 2 ms delay
// - each rising zero crossing sets status bit; enable gates metering irq
// - metering irq holds until zero-cross flag cleared by software
// - 12-bit timeout counter decrements every 160 master clocks
// - timeout counter reloads programmed value on every rising zero crossing
// - programmed timeout value is 0xFFF after reset
// - counter reaching zero sets timeout flag; enable bit 1 gates irq
// - timeout register is readable and writable
// - mode two bit 1 selects period (0) or frequency (1)
// - 16-bit result refreshed once per line period
// - period counts master clock / 10, 60 Hz reads about 6827
// - frequency 0.0625 Hz per count, 60 Hz reads 960
// - dip flag sets after count minus one full cycles below level
// - dip enable gates supply irq until software clears flag
// - dip level compared with absolute filtered voltage
`timescale 1ns/1ps
module lzcsm_monitor
  import lzcsm_pkg::*;
#(
  parameter int DW = 16
) (
  input  wire logic          core_clk_i,
  input  wire logic          sys_rst_i,
  input  wire logic [7:0]    wb_adr_i,
  input  wire logic [31:0]   wb_dat_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic          wb_we_i,
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  output logic      [31:0]   wb_dat_o,
  output logic               wb_ack_o,
  input  wire logic          sample_valid_i,
  input  wire logic [DW-1:0] volt_sample_i,
  input  wire logic [DW-1:0] curr_sample_i,
  output logic      [DW-1:0] curr_out_o,
  output logic               zero_cross_event_o,
  output logic               metering_irq_o,
  output logic               supply_irq_o
);
  // ****************************************
  // register bus
  // ****************************************
  logic [7:0]  mode_control_one;
  logic [7:0]  mode_control_two;
  logic [11:0] crossing_timeout_reload;
  logic [7:0]  dip_cycle_count;
  logic [15:0] dip_threshold_level;
  logic [7:0]  metering_irq_enable_three;
  logic [7:0]  metering_irq_status_three;
  logic [7:0]  supply_mgmt_irq_enable;
  logic [7:0]  supply_mgmt_irq_flags;
  logic [15:0] line_period_or_frequency;

  wire       req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire       wr    = req & wb_we_i;
  wire       wr_l  = wr & wb_sel_i[0];
  wire       wr_h  = wr & wb_sel_i[1];

  function automatic logic hit(input logic [7:0] a, input logic [7:0] idx);
    hit = (a == {idx[5:0], 2'b00});
  endfunction : hit

  // index of documented offsets, low six bits scaled by four
  wire h_pf  = hit(wb_adr_i, IDX_LINE_PERIOD_OR_FREQUENCY);
  wire h_m1  = hit(wb_adr_i, IDX_MODE_ONE);
  wire h_m2  = hit(wb_adr_i, IDX_MODE_TWO);
  wire h_to  = hit(wb_adr_i, IDX_TOUT);
  wire h_dc  = hit(wb_adr_i, IDX_DIP_CYC);
  wire h_dl  = hit(wb_adr_i, IDX_DIP_LVL);
  wire h_me  = hit(wb_adr_i, IDX_MIRQ_EN3);
  wire h_ms  = hit(wb_adr_i, IDX_MIRQ_ST3);
  wire h_se  = hit(wb_adr_i, IDX_SUP_EN);
  wire h_sf  = hit(wb_adr_i, IDX_SUP_FLAGS);

  logic [31:0] rd_mux;
  assign rd_mux =
      h_pf ? {16'h0000, line_period_or_frequency} :
      h_m1 ? {24'h00_0000, mode_control_one} :
      h_m2 ? {24'h00_0000, mode_control_two} :
      h_to ? {20'h0_0000, crossing_timeout_reload} :
      h_dc ? {24'h00_0000, dip_cycle_count} :
      h_dl ? {16'h0000, dip_threshold_level} :
      h_me ? {24'h00_0000, metering_irq_enable_three} :
      h_ms ? {24'h00_0000, metering_irq_status_three} :
      h_se ? {24'h00_0000, supply_mgmt_irq_enable} :
      h_sf ? {24'h00_0000, supply_mgmt_irq_flags} : 32'h0000_0000;

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mode_control_one          <= 8'h00;
      mode_control_two          <= 8'h00;
      crossing_timeout_reload   <= TOUT_RST;
      dip_cycle_count           <= DIPCYC_RST;
      dip_threshold_level       <= DIPLVL_RST;
      metering_irq_enable_three <= 8'h00;
      supply_mgmt_irq_enable    <= 8'h00;
    end else begin
      if (wr_l && h_m1) mode_control_one <= wb_dat_i[7:0];
      if (wr_l && h_m2) mode_control_two <= wb_dat_i[7:0];
      if (wr_l && h_to) crossing_timeout_reload[7:0] <= wb_dat_i[7:0];
      if (wr_h && h_to) crossing_timeout_reload[11:8] <= wb_dat_i[11:8];
      if (wr_l && h_dc) dip_cycle_count <= wb_dat_i[7:0];
      if (wr_l && h_dl) dip_threshold_level[7:0] <= wb_dat_i[7:0];
      if (wr_h && h_dl) dip_threshold_level[15:8] <= wb_dat_i[15:8];
      if (wr_l && h_me) metering_irq_enable_three <= wb_dat_i[7:0];
      if (wr_l && h_se) supply_mgmt_irq_enable <= wb_dat_i[7:0];
    end
  end

  // ****************************************
  // clock enables
  // ****************************************
  // master clock rate scaled onto the core clock; kHz keeps it in int range
  localparam int TO_CYC  = TOUT_DIV * (CLK_HZ / 1000) / (MCLK_HZ / 1000);
  localparam int PER_CYC = PER_DIV * CLK_HZ / MCLK_HZ;
  logic tick_to;
  lzcsm_divider #(.DIV(TO_CYC)) u_div_to (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .tick_o     (tick_to)
  );
  logic [7:0] per_div_cnt;
  wire        per_en = (per_div_cnt == 8'(PER_CYC - 1));
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) per_div_cnt <= 8'h00;
    else           per_div_cnt <= per_en ? 8'h00 : per_div_cnt + 8'h01;
  end

  // ****************************************
  // current integrator
  // ****************************************
  logic signed [DW+3:0] integ_acc;
  wire integ_on = mode_control_one[INTEG_EN_BIT];
  wire signed [DW+3:0] cur_ext = {{4{curr_sample_i[DW-1]}}, curr_sample_i};
  // leaky accumulator: -20 dB/dec and -90 deg above its small corner
  wire signed [DW+3:0] next_integ = integ_acc + cur_ext
                                    - (integ_acc >>> 8);
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      integ_acc  <= '0;
      curr_out_o <= '0;
    end else if (sample_valid_i) begin
      integ_acc  <= integ_on ? next_integ : '0;
      curr_out_o <= integ_on ? next_integ[DW+3:4] : curr_sample_i;
    end
  end

  // ****************************************
  // voltage filter and zero crossing
  // ****************************************
  logic signed [DW+LPF_SHIFT-1:0] lpf_acc;
  wire signed [DW-1:0] lpf_out = lpf_acc[DW+LPF_SHIFT-1:LPF_SHIFT];
  wire signed [DW+LPF_SHIFT-1:0] v_ext =
      {{LPF_SHIFT{volt_sample_i[DW-1]}}, volt_sample_i};
  // single pole y += (x - y) / 2^k
  wire signed [DW+LPF_SHIFT-1:0] next_lpf =
      lpf_acc + v_ext - (lpf_acc >>> LPF_SHIFT);
  wire lpf_byp = mode_control_one[LPF_BYP_BIT];
  wire signed [DW-1:0] zx_src = lpf_byp ? volt_sample_i : lpf_out;
  logic prev_sign;
  logic zx_pulse;
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lpf_acc   <= '0;
      prev_sign <= 1'b0;
      zx_pulse  <= 1'b0;
    end else begin
      zx_pulse <= 1'b0;
      if (sample_valid_i) begin
        lpf_acc   <= next_lpf;
        prev_sign <= zx_src[DW-1];
        zx_pulse  <= prev_sign & ~zx_src[DW-1];  // rising crossing
      end
    end
  end
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) zero_cross_event_o <= 1'b0;
    else           zero_cross_event_o <= zx_pulse;
  end

  // ****************************************
  // timeout counter
  // ****************************************
  logic [11:0] tout_cnt;
  logic        tout_hit;
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tout_cnt <= TOUT_RST;
      tout_hit <= 1'b0;
    end else begin
      tout_hit <= 1'b0;
      if (zx_pulse) tout_cnt <= crossing_timeout_reload;
      else if (tick_to && tout_cnt != 12'h000) begin
        tout_cnt <= tout_cnt - 12'h001;
        tout_hit <= (tout_cnt == 12'h001);
      end
    end
  end

  // ****************************************
  // period and frequency
  // ****************************************
  logic [15:0] per_cnt;
  logic        res_load;
  logic [15:0] next_res;
  wire  [31:0] freq_q = (per_cnt == 16'h0000) ? 32'h0000_0000 :
                        32'(FREQ_NUM) / {16'h0000, per_cnt};
  assign next_res = mode_control_two[FREQ_SEL_BIT] ? freq_q[15:0]
                                                   : per_cnt;
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      per_cnt                  <= 16'h0000;
      line_period_or_frequency <= 16'h0000;
    end else if (zx_pulse) begin
      per_cnt                  <= 16'h0000;
      line_period_or_frequency <= next_res;
    end else if (per_en && per_cnt != 16'hffff) begin
      per_cnt <= per_cnt + 16'h0001;
    end
  end

  // ****************************************
  // dip detection
  // ****************************************
  wire [DW-1:0] abs_v = lpf_out[DW-1] ? DW'(-lpf_out) : lpf_out;
  wire          below = (abs_v < dip_threshold_level);
  logic [7:0]   dip_cyc;
  logic         dip_set;
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dip_cyc <= 8'h00;
      dip_set <= 1'b0;
    end else begin
      dip_set <= 1'b0;
      if (sample_valid_i && !below) dip_cyc <= 8'h00;
      else if (zx_pulse && below) begin
        dip_cyc <= dip_cyc + 8'h01;
        dip_set <= (dip_cyc + 8'h01 == dip_cycle_count - 8'h01);
      end
    end
  end

  // ****************************************
  // flags and interrupts
  // ****************************************
  wire clr_ms = wr_l & h_ms;
  wire clr_sf = wr_l & h_sf;
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      metering_irq_status_three <= 8'h00;
      supply_mgmt_irq_flags     <= 8'h00;
      metering_irq_o            <= 1'b0;
      supply_irq_o              <= 1'b0;
    end else begin
      // write one to clear; a set in the same cycle wins
      metering_irq_status_three <=
          (metering_irq_status_three & ~(clr_ms ? wb_dat_i[7:0] : 8'h00))
          | {6'h00, tout_hit, zx_pulse};
      supply_mgmt_irq_flags <=
          (supply_mgmt_irq_flags & ~(clr_sf ? wb_dat_i[7:0] : 8'h00))
          | {2'b00, dip_set, 5'b00000};
      metering_irq_o <= |(metering_irq_status_three
                          & metering_irq_enable_three);
      supply_irq_o   <= |(supply_mgmt_irq_flags
                          & supply_mgmt_irq_enable);
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  chk_zx_flag_set: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) zx_pulse |=> metering_irq_status_three[ZX_BIT])
    else $error("zero-cross flag not set");
  chk_to_reload: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i)
    zx_pulse |=> tout_cnt == $past(crossing_timeout_reload))
    else $error("timeout not reloaded");
  chk_to_flag: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) tout_hit |=> metering_irq_status_three[CROSSING_TIMEOUT_FLAG_BIT])
    else $error("timeout flag not set");
  chk_irq_hold: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i)
    (metering_irq_status_three[ZX_BIT] & metering_irq_enable_three[ZX_BIT]
     & !clr_ms & !(wr_l & h_me)) |=> ##1 metering_irq_o)
    else $error("metering irq dropped");
  chk_dip_irq: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i)
    (dip_set && supply_mgmt_irq_enable[DIP_BIT] && !(wr_l && h_se))
    |=> ##1 supply_irq_o)
    else $error("supply irq missing");
  chk_integ_off: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i)
    (!integ_on && sample_valid_i) |=> curr_out_o == $past(curr_sample_i))
    else $error("integrator active while off");
  chk_per_update: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i)
    (zx_pulse && !mode_control_two[FREQ_SEL_BIT])
    |=> line_period_or_frequency == $past(per_cnt))
    else $error("period not latched");
  chk_to_dec: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i)
    (tick_to && !zx_pulse && tout_cnt != 12'h000)
    |=> tout_cnt == $past(tout_cnt) - 12'h001)
    else $error("timeout not decremented");
  cov_zx:  cover property (@(posedge core_clk_i) zx_pulse);
  cov_to:  cover property (@(posedge core_clk_i) tout_hit);
  cov_dip: cover property (@(posedge core_clk_i) dip_set);
endmodule : lzcsm_monitor

// file: dv/lzcsm_tb.sv
// testbench: register access, crossing, timeout, period and dip checks
`timescale 1ns/1ps
module tb;
  import lzcsm_pkg::*;
  logic        core_clk_i     = 1'b0;
  logic        sys_rst_i      = 1'b1;
  logic [7:0]  wb_adr_i       = 8'h00;
  logic [31:0] wb_dat_i       = 32'h0000_0000;
  logic [3:0]  wb_sel_i       = 4'h3;
  logic        wb_we_i        = 1'b0;
  logic        wb_cyc_i       = 1'b0;
  logic        wb_stb_i       = 1'b0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        sample_valid_i = 1'b0;
  logic [15:0] volt_sample_i  = 16'h0000;
  logic [15:0] curr_sample_i  = 16'h0123;
  logic [15:0] curr_out_o;
  logic        zero_cross_event_o;
  logic        metering_irq_o;
  logic        supply_irq_o;
  int          n_fail         = 0;
  int          total_checks   = 0;
  logic        wave_on        = 1'b0;
  logic [15:0] amp            = 16'h0400;
  int          hp             = 1000;
  int          ph             = 0;
  logic [31:0] rd;

  always #20 core_clk_i = ~core_clk_i;

  // ****************************************************************
  // square wave line source, dc at +amp while stopped
  // ****************************************************************
  always @(posedge core_clk_i) begin
    sample_valid_i <= ~sys_rst_i;
    if (wave_on) begin
      ph            <= (ph >= 2 * hp - 1) ? 0 : ph + 1;
      volt_sample_i <= (ph < hp) ? 16'h0000 - amp : amp;
    end else begin
      volt_sample_i <= amp;
    end
  end

  lzcsm_monitor i_dut (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .sample_valid_i(sample_valid_i),
    .volt_sample_i(volt_sample_i), .curr_sample_i(curr_sample_i),
    .curr_out_o(curr_out_o), .zero_cross_event_o(zero_cross_event_o),
    .metering_irq_o(metering_irq_o), .supply_irq_o(supply_irq_o)
  );

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic bus(input logic [7:0] idx, input logic we,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk_i);
    wb_adr_i <= {idx[5:0], 2'b00};
    wb_we_i  <= we;
    wb_dat_i <= d;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    if (n >= 50) begin
      n_fail++;
      $display("[ERR] %0t no bus answer", $time);
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge core_clk_i);
  endtask : bus

  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    bus(idx, 1'b0, 32'h0000_0000);
    chk(rd, exp);
  endtask : rdc

  task automatic bitc(input logic [7:0] idx, input int b, input logic e);
    bus(idx, 1'b0, 32'h0000_0000);
    chk(32'(rd[b]), 32'(e));
  endtask : bitc

  task automatic cw(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask : cw

  task automatic wait_zx();
    int n;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (zero_cross_event_o !== 1'b1 && n < 8000);
    if (n >= 8000) begin
      n_fail++;
      $display("[ERR] %0t no crossing seen", $time);
    end
  endtask : wait_zx

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (90000) @(posedge core_clk_i);
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    test_done();
  end

  // ****************************************************************
  // test sequence
  // ****************************************************************
  initial begin
    cw(10);
    sys_rst_i <= 1'b0;
    cw(4);
    chk(32'(curr_out_o), 32'h0000_0123);
    rdc(IDX_MODE_ONE, 32'h0000_0000);
    rdc(IDX_TOUT, 32'h0000_0fff);
    rdc(IDX_DIP_CYC, 32'h0000_0004);
    bus(IDX_TOUT, 1'b1, 32'h0000_0abc);
    rdc(IDX_TOUT, 32'h0000_0abc);
    bus(8'h01, 1'b1, 32'h0000_ffff);
    rdc(8'h01, 32'h0000_0000);
    bus(IDX_LINE_PERIOD_OR_FREQUENCY, 1'b1, 32'h0000_1234);
    rdc(IDX_LINE_PERIOD_OR_FREQUENCY, 32'h0000_0000);
    bus(IDX_MODE_ONE, 1'b1, 32'h0000_0060);
    rdc(IDX_MODE_ONE, 32'h0000_0060);
    // dc gain of 256 through the leak, output scaled down by 16
    cw(3000);
    chk(32'(curr_out_o >= 16'h1230), 32'h0000_0001);
    chk(32'(curr_out_o <= 16'h123f), 32'h0000_0001);
    bus(IDX_MODE_ONE, 1'b1, 32'h0000_0040);
    $display("test registers done");
    bus(IDX_MIRQ_EN3, 1'b1, 32'h0000_0001);
    wave_on <= 1'b1;
    wait_zx();
    wave_on <= 1'b0;
    cw(3);
    bitc(IDX_MIRQ_ST3, ZX_BIT, 1'b1);
    chk(32'(metering_irq_o), 32'h0000_0001);
    cw(50);
    chk(32'(metering_irq_o), 32'h0000_0001);
    bus(IDX_MIRQ_ST3, 1'b1, 32'h0000_0001);
    cw(3);
    chk(32'(metering_irq_o), 32'h0000_0000);
    $display("test crossing done");
    wave_on <= 1'b1;
    bus(IDX_TOUT, 1'b1, 32'h0000_0004);
    cw(4000);
    bus(IDX_MIRQ_ST3, 1'b1, 32'h0000_0003);
    cw(10000);
    bitc(IDX_MIRQ_ST3, CROSSING_TIMEOUT_FLAG_BIT, 1'b0);
    wait_zx();
    wave_on <= 1'b0;
    cw(2500);
    bitc(IDX_MIRQ_ST3, CROSSING_TIMEOUT_FLAG_BIT, 1'b0);
    cw(3500);
    bitc(IDX_MIRQ_ST3, CROSSING_TIMEOUT_FLAG_BIT, 1'b1);
    bus(IDX_MIRQ_EN3, 1'b1, 32'h0000_0002);
    cw(3);
    chk(32'(metering_irq_o), 32'h0000_0001);
    bus(IDX_MIRQ_EN3, 1'b1, 32'h0000_0000);
    bus(IDX_TOUT, 1'b1, 32'h0000_0fff);
    bus(IDX_MIRQ_ST3, 1'b1, 32'h0000_0003);
    $display("test timeout done");
    // line period 7320 core cycles, 61 core cycles per period count
    bus(IDX_MODE_ONE, 1'b1, 32'h0000_0000);
    hp <= 3660;
    wave_on <= 1'b1;
    cw(21960);
    bus(IDX_LINE_PERIOD_OR_FREQUENCY, 1'b0, 32'h0000_0000);
    chk(32'(rd >= 119 && rd <= 121), 32'h0000_0001);
    bus(IDX_MODE_TWO, 1'b1, 32'h0000_0002);
    cw(14640);
    bus(IDX_LINE_PERIOD_OR_FREQUENCY, 1'b0, 32'h0000_0000);
    chk(32'(rd >= FREQ_NUM / 121), 32'h0000_0001);
    chk(32'(rd <= FREQ_NUM / 119), 32'h0000_0001);
    $display("test period done");
    wave_on <= 1'b0;
    hp <= 1000;
    bus(IDX_DIP_CYC, 1'b1, 32'h0000_0004);
    bus(IDX_DIP_LVL, 1'b1, 32'h0000_1000);
    bus(IDX_SUP_FLAGS, 1'b1, 32'h0000_0020);
    bus(IDX_SUP_EN, 1'b1, 32'h0000_0020);
    wave_on <= 1'b1;
    wait_zx();
    wait_zx();
    amp <= 16'h2000;
    cw(200);
    amp <= 16'h0400;
    wait_zx();
    wait_zx();
    cw(5);
    bitc(IDX_SUP_FLAGS, DIP_BIT, 1'b0);
    wait_zx();
    cw(5);
    bitc(IDX_SUP_FLAGS, DIP_BIT, 1'b1);
    chk(32'(supply_irq_o), 32'h0000_0001);
    wave_on <= 1'b0;
    amp <= 16'h2000;
    cw(5);
    bus(IDX_SUP_FLAGS, 1'b1, 32'h0000_0020);
    cw(3);
    chk(32'(supply_irq_o), 32'h0000_0000);
    $display("test dip done");
    test_done();
  end
endmodule : tb
